//--- core/sfs_params.svh
`ifndef SFS_PARAMS_SVH
`define SFS_PARAMS_SVH

`define SFS_CMD_FALL 8'h65
`define SFS_CMD_SBYTE 8'h78
`define SFS_CMD_SWORD 8'h79

`define SFS_FALL_EXP_RST 5'h1E
`define SFS_FALL_EXP_HI 15
`define SFS_FALL_EXP_LO 11
`define SFS_FALL_MAN_HI 10
`define SFS_FALL_MIN_QTR 2
`define SFS_FALL_MAX_QTR 127
`define SFS_FALL_LSB_US 250
`define SFS_CLK_MHZ 200

`define SFS_CLR_BYTE 8'h80
`define SFS_CLR_BUSY 16'h0080
`define SFS_CLR_BUSY_UNK 16'h0180

`define SFS_BIT_BUSY 7
`define SFS_BIT_OFF 6
`define SFS_BIT_VOUT_OV 5
`define SFS_VOUT_OV_POS 7
`define SFS_IOUT_OC_POS 7
`define SFS_VIN_UV_POS 4

`endif

//--- core/sfs_pkg.sv
`default_nettype none
package sfs_pkg;
  typedef enum logic [1:0] {
    SFS_RAMP_IDLE = 2'b00,
    SFS_RAMP_RUN = 2'b01,
    SFS_RAMP_HELD = 2'b10
  } sfs_ramp_state_t;
endpackage : sfs_pkg
`default_nettype wire

//--- core/sfs_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-flop synchroniser, clears to zero
// ----------------------------------------
module sfs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d;
    q_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= meta_d;
      q <= q_d;
    end
  end
endmodule : sfs_sync
`default_nettype wire

//--- core/sfs_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfs_params.svh"
module sfs_regs #(
  parameter int QTR_CYCLES = `SFS_FALL_LSB_US * `SFS_CLK_MHZ,
  parameter int REF_W = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_word,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [15:0] rsp_rdata,
  input wire logic [10:0] nvm_fall_mantissa,
  input wire logic soft_off_req,
  input wire logic [REF_W-1:0] ref_target,
  output logic [REF_W-1:0] ref_code,
  output logic ramp_active,
  output logic [6:0] fall_quarters,
  input wire logic power_off,
  input wire logic power_good_flag,
  input wire logic [7:0] vout_flags,
  input wire logic [7:0] iout_flags,
  input wire logic [7:0] input_flags,
  input wire logic [7:0] temp_flags,
  input wire logic [7:0] cml_flags,
  input wire logic [7:0] mfr_flags,
  input wire logic [7:0] other_flags,
  input wire logic unknown_fault_set,
  output logic invalid_access
);
  // ----------------------------------------
  // resets
  // ----------------------------------------
  logic core_rst_n;
  logic link_rst_n;

  sfs_sync #(.W(1)) u_rst_core (.clk(clk), .rst_n(reset_n), .d(1'b1), .q(core_rst_n));
  sfs_sync #(.W(1)) u_rst_link (.clk(link_clk), .rst_n(reset_n), .d(1'b1), .q(link_rst_n));

  // ----------------------------------------
  // link side: command capture and answer
  // ----------------------------------------
  logic pend_q, pend_d;
  logic req_tog_q, req_tog_d;
  logic busy_tog_q, busy_tog_d;
  logic busy_seen_q, busy_seen_d;
  logic req_write_q, req_write_d;
  logic req_word_q, req_word_d;
  logic [7:0] req_code_q, req_code_d;
  logic [15:0] req_wdata_q, req_wdata_d;
  logic ack_prev_q, ack_prev_d;
  logic rsp_valid_q, rsp_valid_d;
  logic rsp_error_q, rsp_error_d;
  logic [15:0] rsp_rdata_q, rsp_rdata_d;
  logic ack_s;
  logic ack_tog_q, ack_tog_d;
  logic c_err_q, c_err_d;
  logic [15:0] c_data_q, c_data_d;

  sfs_sync #(.W(1)) u_ack_sync (.clk(link_clk), .rst_n(link_rst_n), .d(ack_tog_q), .q(ack_s));

  assign cmd_ready = ~pend_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_error = rsp_error_q;
  assign rsp_rdata = rsp_rdata_q;

  always_comb begin
    pend_d = pend_q;
    req_tog_d = req_tog_q;
    busy_tog_d = busy_tog_q;
    busy_seen_d = busy_seen_q;
    req_write_d = req_write_q;
    req_word_d = req_word_q;
    req_code_d = req_code_q;
    req_wdata_d = req_wdata_q;
    ack_prev_d = ack_s;
    rsp_valid_d = 1'b0;
    rsp_error_d = rsp_error_q;
    rsp_rdata_d = rsp_rdata_q;
    if (cmd_valid && !pend_q) begin
      pend_d = 1'b1;
      req_tog_d = ~req_tog_q;
      busy_seen_d = 1'b0;
      req_write_d = cmd_write;
      req_word_d = cmd_word;
      req_code_d = cmd_code;
      req_wdata_d = cmd_wdata;
    end else if (cmd_valid && !busy_seen_q) begin
      // one busy event per pending transfer keeps toggles far apart
      busy_tog_d = ~busy_tog_q;
      busy_seen_d = 1'b1;
    end
    if (ack_s != ack_prev_q) begin
      pend_d = 1'b0;
      rsp_valid_d = 1'b1;
      rsp_error_d = c_err_q;
      rsp_rdata_d = c_data_q;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pend_q <= 1'b0;
      req_tog_q <= 1'b0;
      busy_tog_q <= 1'b0;
      busy_seen_q <= 1'b0;
      req_write_q <= 1'b0;
      req_word_q <= 1'b0;
      req_code_q <= 8'h00;
      req_wdata_q <= 16'h0000;
      ack_prev_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_error_q <= 1'b0;
      rsp_rdata_q <= 16'h0000;
    end else begin
      pend_q <= pend_d;
      req_tog_q <= req_tog_d;
      busy_tog_q <= busy_tog_d;
      busy_seen_q <= busy_seen_d;
      req_write_q <= req_write_d;
      req_word_q <= req_word_d;
      req_code_q <= req_code_d;
      req_wdata_q <= req_wdata_d;
      ack_prev_q <= ack_prev_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_error_q <= rsp_error_d;
      rsp_rdata_q <= rsp_rdata_d;
    end
  end

  a_link_answer: assert property (@(posedge link_clk) disable iff (!link_rst_n)
    rsp_valid_q |-> !pend_q && $past(pend_q)) else $error("answer without pending command");

  // ----------------------------------------
  // core side: fault summary
  // ----------------------------------------
  logic [1:0] evt_s;
  logic req_prev_q, req_prev_d;
  logic bz_prev_q, bz_prev_d;
  logic acc_go;
  logic busy_evt;
  logic busy_q, busy_d;
  logic unk_q, unk_d;
  logic busy_clr;
  logic unk_clr;
  logic none_above;
  logic [7:0] sum_byte;
  logic [7:0] sum_upper;
  logic [7:0] vout_rest;
  logic [7:0] iout_rest;
  logic [7:0] input_rest;

  sfs_sync #(.W(2)) u_evt_sync (.clk(clk), .rst_n(core_rst_n), .d({busy_tog_q, req_tog_q}), .q(evt_s));

  assign acc_go = evt_s[0] ^ req_prev_q;
  assign busy_evt = evt_s[1] ^ bz_prev_q;

  always_comb begin
    vout_rest = vout_flags;
    vout_rest[`SFS_VOUT_OV_POS] = 1'b0;
    iout_rest = iout_flags;
    iout_rest[`SFS_IOUT_OC_POS] = 1'b0;
    input_rest = input_flags;
    input_rest[`SFS_VIN_UV_POS] = 1'b0;
    none_above = (|vout_rest) | (|iout_rest) | (|input_rest) | (|mfr_flags) | (|other_flags) | unk_q;
    // one byte serves both status commands
    sum_byte = {busy_q,
                power_off,
                vout_flags[`SFS_VOUT_OV_POS],
                iout_flags[`SFS_IOUT_OC_POS],
                input_flags[`SFS_VIN_UV_POS],
                |temp_flags,
                |cml_flags,
                none_above};
    sum_upper = {|vout_flags, |iout_flags, |input_flags, |mfr_flags,
                 power_good_flag,
                 1'b0, |other_flags, 1'b0};
  end

  // ----------------------------------------
  // core side: command execution
  // ----------------------------------------
  logic loaded_q, loaded_d;
  logic [15:0] fall_word_q, fall_word_d;
  logic cml_evt_q, cml_evt_d;
  logic signed [31:0] wr_qtr;

  function automatic logic signed [31:0] qtr_of(input logic [15:0] w);
    logic signed [4:0] e;
    logic signed [31:0] m;
    int sh;
    e = signed'(w[`SFS_FALL_EXP_HI:`SFS_FALL_EXP_LO]);
    m = 32'(signed'(w[`SFS_FALL_MAN_HI:0]));
    sh = int'(e) + 2;
    if (sh >= 0) begin
      qtr_of = m <<< sh;
    end else begin
      qtr_of = m >>> (-sh);
    end
  endfunction : qtr_of

  assign wr_qtr = qtr_of(req_wdata_q);
  assign invalid_access = cml_evt_q;

  always_comb begin
    req_prev_d = evt_s[0];
    bz_prev_d = evt_s[1];
    loaded_d = 1'b1;
    fall_word_d = fall_word_q;
    ack_tog_d = ack_tog_q;
    c_err_d = c_err_q;
    c_data_d = c_data_q;
    cml_evt_d = 1'b0;
    busy_clr = 1'b0;
    unk_clr = 1'b0;
    if (!loaded_q) begin
      fall_word_d = {`SFS_FALL_EXP_RST, nvm_fall_mantissa};
    end else if (acc_go) begin
      ack_tog_d = ~ack_tog_q;
      c_err_d = 1'b0;
      c_data_d = 16'h0000;
      if (req_code_q == `SFS_CMD_FALL) begin
        if (!req_word_q) begin
          c_err_d = 1'b1;
        end else if (req_write_q && wr_qtr > `SFS_FALL_MAX_QTR) begin
          c_err_d = 1'b1;
        end else if (req_write_q) begin
          fall_word_d = req_wdata_q;
        end else begin
          c_data_d = fall_word_q;
        end
      end else if (req_code_q == `SFS_CMD_SBYTE) begin
        if (req_word_q) begin
          c_err_d = 1'b1;
        end else if (req_write_q) begin
          busy_clr = (req_wdata_q[7:0] == `SFS_CLR_BYTE);
        end else begin
          c_data_d = {8'h00, sum_byte};
        end
      end else if (req_code_q == `SFS_CMD_SWORD) begin
        if (!req_word_q) begin
          c_err_d = 1'b1;
        end else if (req_write_q) begin
          busy_clr = (req_wdata_q == `SFS_CLR_BUSY) || (req_wdata_q == `SFS_CLR_BUSY_UNK);
          unk_clr = (req_wdata_q == `SFS_CLR_BUSY_UNK);
        end else begin
          c_data_d = {sum_upper, sum_byte};
        end
      end else begin
        c_err_d = 1'b1;
      end
      cml_evt_d = c_err_d;
    end
    // a new event wins over a clear in the same cycle
    busy_d = busy_evt ? 1'b1 : (busy_clr ? 1'b0 : busy_q);
    unk_d = unknown_fault_set ? 1'b1 : (unk_clr ? 1'b0 : unk_q);
  end

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      req_prev_q <= 1'b0;
      bz_prev_q <= 1'b0;
      loaded_q <= 1'b0;
      fall_word_q <= {`SFS_FALL_EXP_RST, 11'h000};
      ack_tog_q <= 1'b0;
      c_err_q <= 1'b0;
      c_data_q <= 16'h0000;
      cml_evt_q <= 1'b0;
      busy_q <= 1'b0;
      unk_q <= 1'b0;
    end else begin
      req_prev_q <= req_prev_d;
      bz_prev_q <= bz_prev_d;
      loaded_q <= loaded_d;
      fall_word_q <= fall_word_d;
      ack_tog_q <= ack_tog_d;
      c_err_q <= c_err_d;
      c_data_q <= c_data_d;
      cml_evt_q <= cml_evt_d;
      busy_q <= busy_d;
      unk_q <= unk_d;
    end
  end

  // ----------------------------------------
  // soft-off ramp
  // ----------------------------------------
  logic [6:0] eff_qtr_q, eff_qtr_d;
  sfs_pkg::sfs_ramp_state_t st_q, st_d;
  logic [REF_W-1:0] code_q, code_d;
  logic [REF_W-1:0] start_q, start_d;
  logic [23:0] span_q, span_d;
  logic [23:0] acc_q, acc_d;
  logic [23:0] acc_sum;
  logic signed [31:0] cur_qtr;

  assign cur_qtr = qtr_of(fall_word_q);
  assign ref_code = code_q;
  assign fall_quarters = eff_qtr_q;
  assign ramp_active = (st_q == sfs_pkg::SFS_RAMP_RUN);
  assign acc_sum = 24'(acc_q + 24'(start_q));

  always_comb begin
    if (cur_qtr < `SFS_FALL_MIN_QTR) begin
      eff_qtr_d = 7'(`SFS_FALL_MIN_QTR);
    end else if (cur_qtr > `SFS_FALL_MAX_QTR) begin
      eff_qtr_d = 7'(`SFS_FALL_MAX_QTR);
    end else begin
      eff_qtr_d = cur_qtr[6:0];
    end
  end

  always_comb begin
    st_d = st_q;
    code_d = code_q;
    start_d = start_q;
    span_d = span_q;
    acc_d = acc_q;
    case (st_q)
      sfs_pkg::SFS_RAMP_IDLE: begin
        code_d = ref_target;
        if (soft_off_req) begin
          st_d = sfs_pkg::SFS_RAMP_RUN;
          code_d = code_q;
          start_d = code_q;
          span_d = 24'(eff_qtr_q * QTR_CYCLES);
          acc_d = 24'h000000;
        end
      end
      sfs_pkg::SFS_RAMP_RUN: begin
        if (!soft_off_req) begin
          st_d = sfs_pkg::SFS_RAMP_IDLE;
        end else if (code_q == '0) begin
          st_d = sfs_pkg::SFS_RAMP_HELD;
        end else if (acc_sum >= span_q) begin
          // at most one code per cycle: span must not be below the start level
          // step rate scales with the start level so the span stays fixed
          acc_d = acc_sum - span_q;
          code_d = code_q - 1'b1;
        end else begin
          acc_d = acc_sum;
        end
      end
      sfs_pkg::SFS_RAMP_HELD: begin
        code_d = '0;
        if (!soft_off_req) begin
          st_d = sfs_pkg::SFS_RAMP_IDLE;
        end
      end
      default: begin
        st_d = sfs_pkg::SFS_RAMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      eff_qtr_q <= 7'(`SFS_FALL_MIN_QTR);
      st_q <= sfs_pkg::SFS_RAMP_IDLE;
      code_q <= '0;
      start_q <= '0;
      span_q <= 24'h000001;
      acc_q <= 24'h000000;
    end else begin
      eff_qtr_q <= eff_qtr_d;
      st_q <= st_d;
      code_q <= code_d;
      start_q <= start_d;
      span_q <= span_d;
      acc_q <= acc_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_busy_set: assert property (@(posedge clk) disable iff (!core_rst_n)
    busy_evt |=> busy_q) else $error("busy event lost");
  a_busy_clear: assert property (@(posedge clk) disable iff (!core_rst_n)
    acc_go && loaded_q && req_write_q && !req_word_q && req_code_q == 8'h78 && req_wdata_q[7:0] == 8'h80
    && !busy_evt |=> !busy_q) else $error("busy not cleared by 80h");
  a_word_clear: assert property (@(posedge clk) disable iff (!core_rst_n)
    acc_go && loaded_q && req_write_q && req_word_q && req_code_q == 8'h79 && req_wdata_q == 16'h0180
    && !unknown_fault_set |=> !unk_q) else $error("unknown flag not cleared by 0180h");
  a_low_byte_same: assert property (@(posedge clk) disable iff (!core_rst_n)
    acc_go && loaded_q && !req_write_q && req_code_q == 8'h79 && req_word_q
    |=> c_data_q[7:0] == $past(sum_byte) && c_data_q[10] == 1'b0 && c_data_q[8] == 1'b0)
    else $error("status word low byte differs");
  a_off_live: assert property (@(posedge clk) disable iff (!core_rst_n)
    acc_go && loaded_q && !req_write_q && req_code_q == 8'h78 && !req_word_q
    |=> c_data_q[6] == $past(power_off) && c_data_q[5] == $past(vout_flags[7]))
    else $error("summary byte live bits wrong");
  a_exp_reset: assert property (@(posedge clk) disable iff (!core_rst_n)
    $rose(loaded_q) |-> fall_word_q[15:11] == 5'h1E) else $error("exponent reset value wrong");
  a_reject_high: assert property (@(posedge clk) disable iff (!core_rst_n)
    acc_go && loaded_q && req_write_q && req_word_q && req_code_q == 8'h65 && wr_qtr > 127
    |=> fall_word_q == $past(fall_word_q) && cml_evt_q) else $error("out of range fall time accepted");
  a_min_clamp: assert property (@(posedge clk) disable iff (!core_rst_n)
    eff_qtr_q >= 7'h02 && eff_qtr_q <= 7'h7F) else $error("applied fall time out of range");
  a_ramp_down: assert property (@(posedge clk) disable iff (!core_rst_n)
    st_q == sfs_pkg::SFS_RAMP_RUN && soft_off_req |=> code_q <= $past(code_q)
    && $past(code_q) - code_q <= 1) else $error("ramp not falling steadily");
endmodule : sfs_regs
`default_nettype wire

//--- testbench/sfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// command-side host: one command at a time
// ----------------------------------------
module sfs_host_model (
  input wire logic link_clk,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic cmd_write,
  output logic cmd_word,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  input wire logic [15:0] rsp_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_word = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  task automatic xfer(input logic w, input logic wd, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic e);
    int n;
    n = 0;
    @(negedge link_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_word = wd;
    cmd_code = c;
    cmd_wdata = d;
    do @(posedge link_clk); while (cmd_ready !== 1'b1 && ++n < 50);
    @(negedge link_clk);
    cmd_valid = 1'b0;
    // released code and data lines show the inverse so a stale value is never mistaken for a live one
    cmd_code = ~c;
    cmd_wdata = ~d;
    while (rsp_valid !== 1'b1 && n < 80) begin
      @(negedge link_clk);
      n++;
    end
    q = (n < 80) ? rsp_rdata : 16'hXXXX;
    e = (n < 80) ? rsp_error : 1'bx;
  endtask : xfer

  // offer a command while one is pending; the device must drop it and flag busy
  task automatic poke();
    @(negedge link_clk);
    cmd_valid = 1'b1;
    @(negedge link_clk);
    cmd_valid = 1'b0;
  endtask : poke
endmodule : sfs_host_model
`default_nettype wire

//--- testbench/test_soft_off_and_fault_summary_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_soft_off_and_fault_summary_regs;
  logic clk, link_clk, reset_n, cmd_valid, cmd_ready, cmd_write, cmd_word, rsp_valid, rsp_error;
  logic [7:0] cmd_code, vout_flags, iout_flags, input_flags, temp_flags, cml_flags, mfr_flags, other_flags;
  logic [15:0] cmd_wdata, rsp_rdata, q, w;
  logic [10:0] nvm_fall_mantissa;
  logic soft_off_req, power_off, power_good_flag, unknown_fault_set, invalid_access, ramp_active, e, inv_seen;
  logic [11:0] ref_target, ref_code;
  logic [6:0] fall_quarters;
  int bad_count, total_checks, cyc, n, m, span;
  localparam int QTR_SIM = 20;

  sfs_regs #(.QTR_CYCLES(QTR_SIM), .REF_W(12)) dut_u (.clk(clk), .reset_n(reset_n), .link_clk(link_clk),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_word(cmd_word),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
    .rsp_rdata(rsp_rdata), .nvm_fall_mantissa(nvm_fall_mantissa), .soft_off_req(soft_off_req),
    .ref_target(ref_target), .ref_code(ref_code), .ramp_active(ramp_active), .fall_quarters(fall_quarters),
    .power_off(power_off), .power_good_flag(power_good_flag), .vout_flags(vout_flags),
    .iout_flags(iout_flags), .input_flags(input_flags), .temp_flags(temp_flags), .cml_flags(cml_flags),
    .mfr_flags(mfr_flags), .other_flags(other_flags), .unknown_fault_set(unknown_fault_set),
    .invalid_access(invalid_access));

  sfs_host_model host_u (.link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    if (invalid_access === 1'b1) inv_seen = 1'b1;
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      complete_run();
    end
  end

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    total_checks++;
    if (got !== ex) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  function automatic logic [15:0] exp_word(input logic busy, input logic unk);
    logic [7:0] lo, hi;
    lo = {busy, power_off, vout_flags[7], iout_flags[7], input_flags[4], |temp_flags, |cml_flags,
          |{vout_flags[6:0], iout_flags[6:0], input_flags[7:5], input_flags[3:0], mfr_flags, other_flags, unk}};
    hi = {|vout_flags, |iout_flags, |input_flags, |mfr_flags, power_good_flag, 1'b0, |other_flags, 1'b0};
    return {hi, lo};
  endfunction : exp_word

  function automatic logic [6:0] exp_fq(input int mv);
    return (mv < 2) ? 7'h02 : 7'(mv);
  endfunction : exp_fq

  task automatic set_flags(input logic rnd);
    @(negedge clk);
    {vout_flags, iout_flags, input_flags, temp_flags} = rnd ? $urandom : 32'h0;
    {cml_flags, mfr_flags, other_flags} = rnd ? 24'($urandom) & 24'h1F3F7F : 24'h0;
    power_off = rnd ? 1'($urandom) : 1'b0;
    power_good_flag = rnd ? 1'($urandom) : 1'b0;
  endtask : set_flags

  task automatic mk_busy();
    fork
      host_u.xfer(1'b0, 1'b1, 8'h79, 16'h0000, q, e);
      begin
        repeat (3) @(negedge link_clk);
        host_u.poke();
      end
    join
  endtask : mk_busy

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(98403));
    {reset_n, soft_off_req, unknown_fault_set, inv_seen} = 4'h0;
    {bad_count, total_checks, cyc} = '0;
    ref_target = 12'h000;
    nvm_fall_mantissa = 11'(2 + $urandom_range(125));
    set_flags(1'b0);
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (20) @(negedge clk);
    host_u.xfer(1'b0, 1'b1, 8'h65, 16'h0000, q, e);
    chk("fall_reset", {5'h1E, nvm_fall_mantissa}, q);
    chk("fall_q_reset", 16'(exp_fq(int'(nvm_fall_mantissa))), 16'(fall_quarters));
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      m = (i < 4) ? (i == 3 ? 127 : i) : 2 + $urandom_range(125);
      w = {5'h1E, 11'(m)};
      host_u.xfer(1'b1, 1'b1, 8'h65, w, q, e);
      chk("fall_wr_err", 16'h0000, 16'(e));
      host_u.xfer(1'b0, 1'b1, 8'h65, 16'h0000, q, e);
      chk("fall_rd", w, q);
      repeat (6) @(negedge clk);
      chk("fall_q", 16'(exp_fq(m)), 16'(fall_quarters));
    end
    inv_seen = 1'b0;
    host_u.xfer(1'b1, 1'b1, 8'h65, {5'h1E, 11'd128}, q, e);
    chk("fall_over_err", 16'h0001, 16'(e));
    repeat (4) @(negedge clk);
    chk("fall_over_flag", 16'h0001, 16'(inv_seen));
    host_u.xfer(1'b0, 1'b1, 8'h65, 16'h0000, q, e);
    chk("fall_kept", w, q);
    host_u.xfer(1'b0, 1'b0, 8'h79, 16'h0000, q, e);
    chk("word_as_byte_err", 16'h0001, 16'(e));
    host_u.xfer(1'b0, 1'b1, 8'h66, 16'h0000, q, e);
    chk("unknown_code_err", 16'h0001, 16'(e));
    host_u.xfer(1'b0, 1'b0, 8'h65, 16'h0000, q, e);
    chk("fall_as_byte_err", 16'h0001, 16'(e));
    $display("test fall time done");
    for (int i = 0; i < 20; i++) begin
      set_flags(1'b1);
      host_u.xfer(1'b0, 1'b1, 8'h79, 16'h0000, q, e);
      chk("status_word", exp_word(1'b0, 1'b0), q);
      w = exp_word(1'b0, 1'b0);
      host_u.xfer(1'b0, 1'b0, 8'h78, 16'h0000, q, e);
      chk("status_byte", {8'h00, w[7:0]}, q);
    end
    set_flags(1'b0);
    host_u.xfer(1'b0, 1'b1, 8'h79, 16'h0000, q, e);
    chk("flags_cleared", 16'h0000, q);
    $display("test summary done");
    mk_busy();
    host_u.xfer(1'b0, 1'b0, 8'h78, 16'h0000, q, e);
    chk("busy_set", 16'h0080, q);
    host_u.xfer(1'b1, 1'b0, 8'h78, 16'h0080, q, e);
    host_u.xfer(1'b0, 1'b0, 8'h78, 16'h0000, q, e);
    chk("busy_byte_clr", 16'h0000, q);
    mk_busy();
    host_u.xfer(1'b1, 1'b1, 8'h79, 16'h0080, q, e);
    host_u.xfer(1'b0, 1'b1, 8'h79, 16'h0000, q, e);
    chk("busy_word_clr", 16'h0000, q);
    @(negedge clk) unknown_fault_set = 1'b1;
    @(negedge clk) unknown_fault_set = 1'b0;
    mk_busy();
    host_u.xfer(1'b0, 1'b1, 8'h79, 16'h0000, q, e);
    chk("busy_unknown", exp_word(1'b1, 1'b1), q);
    host_u.xfer(1'b1, 1'b1, 8'h79, 16'h0180, q, e);
    host_u.xfer(1'b0, 1'b1, 8'h79, 16'h0000, q, e);
    chk("unknown_clr", 16'h0000, q);
    $display("test busy done");
    for (int i = 0; i < 4; i++) begin
      m = (i < 2) ? 0 : 10;
      span = int'(exp_fq(m)) * QTR_SIM;
      host_u.xfer(1'b1, 1'b1, 8'h65, {5'h1E, 11'(m)}, q, e);
      @(negedge clk);
      // one code step per cycle at most: start level kept within the span
      ref_target = (i == 3) ? 12'(span) : 12'(1 + $urandom_range(span - 1));
      repeat (8) @(negedge clk);
      chk("ref_track", 16'(ref_target), 16'(ref_code));
      soft_off_req = 1'b1;
      n = 0;
      @(negedge clk);
      chk("ramp_on", 16'h0001, 16'(ramp_active));
      while (ref_code !== 12'h000 && n < 2000) begin
        @(negedge clk);
        n++;
      end
      chk("ramp_len", 16'h0001, 16'(n >= span - 2 && n <= span + 1));
      soft_off_req = 1'b0;
    end
    $display("test soft off done");
    complete_run();
  end
endmodule : test_soft_off_and_fault_summary_regs
`default_nettype wire
